// ==== inc/dus_defs.vh ====
// Constants for the dual channel status pin block
`ifndef DUS_DEFS_VH
`define DUS_DEFS_VH
`define DUS_FIFO_DEPTH   16
`define DUS_CNT_W        5
`define DUS_MSR_CTS_BIT  4
`define DUS_TRIG_W       2
`define DUS_TRIG_1       2'h0
`define DUS_TRIG_4       2'h1
`define DUS_TRIG_8       2'h2
`define DUS_TRIG_14      2'h3
`define DUS_LVL_1        5'h01
`define DUS_LVL_4        5'h04
`define DUS_LVL_8        5'h08
`define DUS_LVL_14       5'h0E
`define DUS_CNT_ZERO     5'h00
`define DUS_CNT_ONE      5'h01
`define DUS_MSR_RESET    8'h00
`define DUS_SEL_A        1'b0
`define DUS_LINE_IDLE    1'b1
`define DUS_FLAG_CLR     1'b0
`define DUS_READ_IDLE    1'b0
`define DUS_AVAIL_N_RST  1'b1
`define DUS_SPACE_N_RST  1'b0
`endif

// ==== logic/dus_chan.v ====
// Per-channel occupancy tracking and status pins
`timescale 1ns/1ps
`include "dus_defs.vh"
module dus_chan #(
   parameter DEPTH = `DUS_FIFO_DEPTH
) (
   // Clock and reset
   input  wire       clk,
   input  wire       srst,
   // Occupancy events
   input  wire       rx_push,
   input  wire       rx_pop,
   input  wire       tx_push,
   input  wire       tx_pop,
   // Configuration
   input  wire       fifo_en,
   input  wire [1:0] rx_trig,
   input  wire       cts_n,
   // Status
   output reg        rx_avail_n_q,
   output reg        tx_space_n_q,
   output reg  [7:0] modem_status_reg_q,
   output wire [4:0] rx_count,
   output wire [4:0] tx_count
);
   reg  [4:0] rx_cnt_q;
   reg  [4:0] tx_cnt_q;
   reg  [4:0] rx_cnt_d;
   reg  [4:0] tx_cnt_d;
   reg  [4:0] cap;
   reg  [4:0] trig_lvl;
   assign rx_count = rx_cnt_q;
   assign tx_count = tx_cnt_q;
   always @* begin
      // Without FIFO only the single holding register counts
      cap = fifo_en ? DEPTH[4:0] : `DUS_CNT_ONE;
      case (rx_trig)
         `DUS_TRIG_4:  trig_lvl = `DUS_LVL_4;
         `DUS_TRIG_8:  trig_lvl = `DUS_LVL_8;
         `DUS_TRIG_14: trig_lvl = `DUS_LVL_14;
         default:      trig_lvl = `DUS_LVL_1;
      endcase
      if (!fifo_en)
         trig_lvl = `DUS_LVL_1;
      rx_cnt_d = rx_cnt_q;
      if (rx_push && !rx_pop && rx_cnt_q < cap)
         rx_cnt_d = rx_cnt_q + `DUS_CNT_ONE;
      else if (rx_pop && !rx_push && rx_cnt_q != `DUS_CNT_ZERO)
         rx_cnt_d = rx_cnt_q - `DUS_CNT_ONE;
      tx_cnt_d = tx_cnt_q;
      if (tx_push && !tx_pop && tx_cnt_q < cap)
         tx_cnt_d = tx_cnt_q + `DUS_CNT_ONE;
      else if (tx_pop && !tx_push && tx_cnt_q != `DUS_CNT_ZERO)
         tx_cnt_d = tx_cnt_q - `DUS_CNT_ONE;
   end
   always @(posedge clk) begin
      if (srst) begin
         rx_cnt_q           <= `DUS_CNT_ZERO;
         tx_cnt_q           <= `DUS_CNT_ZERO;
         rx_avail_n_q       <= `DUS_AVAIL_N_RST;
         tx_space_n_q       <= `DUS_SPACE_N_RST;
         modem_status_reg_q <= `DUS_MSR_RESET;
      end else begin
         rx_cnt_q     <= rx_cnt_d;
         tx_cnt_q     <= tx_cnt_d;
         // Low once trigger level reached, high when empty
         rx_avail_n_q <= !(rx_cnt_d >= trig_lvl);
         // Low while a free slot exists, high when full
         tx_space_n_q <= !(tx_cnt_d < cap);
         modem_status_reg_q                   <= `DUS_MSR_RESET;
         modem_status_reg_q[`DUS_MSR_CTS_BIT] <= ~cts_n;
      end
   end
endmodule // dus_chan

// ==== logic/dus_top.v ====
// Dual channel status and handshake pins top level
`timescale 1ns/1ps
`include "dus_defs.vh"
//
// Contract
// - Host read activity output is high while the host performs a read cycle, registered one clock late.
// - Holding master reset high returns all registers and outputs to reset state.
// - During reset each channel holds its transmit output idle and ignores receive input.
// - Receive ready goes low when the received count reaches the trigger level (one character without FIFO).
// - Receive ready is high when empty or when the trigger level is not reached.
// - Transmit ready is low while at least one transmit location is free.
// - Transmit ready goes high once the transmit store has no free location.
// - Clear to send input is shown inverted in bit 4 of the modem status register.
// - Clear to send never gates transmit or receive operation.
// - A low read strobe starts a read and the device drives the addressed data.
module dus_top #(
   parameter DEPTH = `DUS_FIFO_DEPTH
) (
   // Clock and reset
   input  wire       CLK,
   input  wire       SRST,
   // Host read side
   input  wire       HOST_READ_STROBE_N,
   input  wire       HOST_SEL_B,
   output wire       HOST_READ_ACTIVE,
   output wire [7:0] HOST_MSR_DATA,
   // Occupancy events, channel A
   input  wire       RX_PUSH_A,
   input  wire       RX_POP_A,
   input  wire       TX_PUSH_A,
   input  wire       TX_POP_A,
   // Occupancy events, channel B
   input  wire       RX_PUSH_B,
   input  wire       RX_POP_B,
   input  wire       TX_PUSH_B,
   input  wire       TX_POP_B,
   // Configuration
   input  wire       FIFO_EN_A,
   input  wire       FIFO_EN_B,
   input  wire [1:0] RX_TRIG_A,
   input  wire [1:0] RX_TRIG_B,
   // Serial and modem pins
   input  wire       RX_A,
   input  wire       RX_B,
   input  wire       TX_DATA_A,
   input  wire       TX_DATA_B,
   output wire       TX_A,
   output wire       TX_B,
   output wire       RX_SEEN_A,
   output wire       RX_SEEN_B,
   input  wire       CTS_N_A,
   input  wire       CTS_N_B,
   input  wire       CARRIER_DETECT_N_A,
   input  wire       CARRIER_DETECT_N_B,
   output wire       CARRIER_A,
   output wire       CARRIER_B,
   // Status pins
   output wire       RX_AVAIL_N_A,
   output wire       RX_AVAIL_N_B,
   output wire       TX_SPACE_N_A,
   output wire       TX_SPACE_N_B
);

   // Status words of the two channels
   wire [7:0] msr_a;
   wire [7:0] msr_b;

   // Host side registers
   reg        host_read_active_q;
   reg        host_read_active_d;
   reg  [7:0] host_msr_data_q;
   reg  [7:0] host_msr_data_d;
   // Status word of the addressed channel
   reg  [7:0] msr_sel;

   // Channel A pin registers
   reg        tx_a_q;
   reg        tx_a_d;
   reg        rx_seen_a_q;
   reg        rx_seen_a_d;
   reg        carrier_a_q;
   reg        carrier_a_d;

   // Channel B pin registers
   reg        tx_b_q;
   reg        tx_b_d;
   reg        rx_seen_b_q;
   reg        rx_seen_b_d;
   reg        carrier_b_q;
   reg        carrier_b_d;

   // Outputs leave straight from their flip-flops
   assign HOST_READ_ACTIVE = host_read_active_q;
   assign HOST_MSR_DATA    = host_msr_data_q;
   assign TX_A             = tx_a_q;
   assign TX_B             = tx_b_q;
   assign RX_SEEN_A        = rx_seen_a_q;
   assign RX_SEEN_B        = rx_seen_b_q;
   assign CARRIER_A        = carrier_a_q;
   assign CARRIER_B        = carrier_b_q;

   dus_chan #(.DEPTH(DEPTH)) u_cha (
      .clk                (CLK),
      .srst               (SRST),
      .rx_push            (RX_PUSH_A),
      .rx_pop             (RX_POP_A),
      .tx_push            (TX_PUSH_A),
      .tx_pop             (TX_POP_A),
      .fifo_en            (FIFO_EN_A),
      .rx_trig            (RX_TRIG_A),
      .cts_n              (CTS_N_A),
      .rx_avail_n_q       (RX_AVAIL_N_A),
      .tx_space_n_q       (TX_SPACE_N_A),
      .modem_status_reg_q (msr_a),
      .rx_count           (),
      .tx_count           ()
   );

   dus_chan #(.DEPTH(DEPTH)) u_chb (
      .clk                (CLK),
      .srst               (SRST),
      .rx_push            (RX_PUSH_B),
      .rx_pop             (RX_POP_B),
      .tx_push            (TX_PUSH_B),
      .tx_pop             (TX_POP_B),
      .fifo_en            (FIFO_EN_B),
      .rx_trig            (RX_TRIG_B),
      .cts_n              (CTS_N_B),
      .rx_avail_n_q       (RX_AVAIL_N_B),
      .tx_space_n_q       (TX_SPACE_N_B),
      .modem_status_reg_q (msr_b),
      .rx_count           (),
      .tx_count           ()
   );

   // Read activity follows the strobe one clock late
   always @* begin
      host_read_active_d = ~HOST_READ_STROBE_N;
   end
   always @(posedge CLK) begin
      if (SRST)
         host_read_active_q <= `DUS_READ_IDLE;
      else
         host_read_active_q <= host_read_active_d;
   end

   // Data only during a read, zero keeps a shared bus quiet
   always @* begin
      case (HOST_SEL_B)
         `DUS_SEL_A: msr_sel = msr_a;
         default:    msr_sel = msr_b;
      endcase
      host_msr_data_d = `DUS_MSR_RESET;
      if (!HOST_READ_STROBE_N)
         host_msr_data_d = msr_sel;
   end
   always @(posedge CLK) begin
      if (SRST)
         host_msr_data_q <= `DUS_MSR_RESET;
      else
         host_msr_data_q <= host_msr_data_d;
   end

   // Channel A transmit line, never gated by clear to send
   always @* begin
      tx_a_d = TX_DATA_A;
   end
   always @(posedge CLK) begin
      // Line held at idle so the far end sees no start bit
      if (SRST)
         tx_a_q <= `DUS_LINE_IDLE;
      else
         tx_a_q <= tx_a_d;
   end

   // Channel A receive line and carrier flag
   always @* begin
      rx_seen_a_d = RX_A;
      carrier_a_d = ~CARRIER_DETECT_N_A;
   end
   always @(posedge CLK) begin
      // Receive input ignored while reset is held
      if (SRST) begin
         rx_seen_a_q <= `DUS_LINE_IDLE;
         carrier_a_q <= `DUS_FLAG_CLR;
      end else begin
         rx_seen_a_q <= rx_seen_a_d;
         carrier_a_q <= carrier_a_d;
      end
   end

   // Channel B transmit line, never gated by clear to send
   always @* begin
      tx_b_d = TX_DATA_B;
   end
   always @(posedge CLK) begin
      // Line held at idle so the far end sees no start bit
      if (SRST)
         tx_b_q <= `DUS_LINE_IDLE;
      else
         tx_b_q <= tx_b_d;
   end

   // Channel B receive line and carrier flag
   always @* begin
      rx_seen_b_d = RX_B;
      carrier_b_d = ~CARRIER_DETECT_N_B;
   end
   always @(posedge CLK) begin
      // Receive input ignored while reset is held
      if (SRST) begin
         rx_seen_b_q <= `DUS_LINE_IDLE;
         carrier_b_q <= `DUS_FLAG_CLR;
      end else begin
         rx_seen_b_q <= rx_seen_b_d;
         carrier_b_q <= carrier_b_d;
      end
   end

endmodule // dus_top

// ==== dv/dus_properties.sv ====
// Status pin checker
`timescale 1ns/1ps
module dus_properties (
   input wire logic       CLK, SRST, HOST_READ_STROBE_N, HOST_SEL_B, HOST_READ_ACTIVE,
   input wire logic [7:0] HOST_MSR_DATA,
   input wire logic       CTS_N_A, TX_A, TX_DATA_A, RX_PUSH_A, RX_POP_A, TX_PUSH_A,
   input wire logic       TX_POP_A, FIFO_EN_A, RX_AVAIL_N_A, TX_SPACE_N_A,
   input wire logic [1:0] RX_TRIG_A
);
   default clocking @(posedge CLK); endclocking
   default disable iff (SRST);
   sequence s_rd2; !HOST_READ_STROBE_N [*2]; endsequence
   a_read_high: assert property (s_rd2 |-> HOST_READ_ACTIVE) else $error("rd low");
   a_read_low: assert property (HOST_READ_STROBE_N |=> !HOST_READ_ACTIVE)
      else $error("rd high");
   a_cts_shown: assert property (!$past(SRST) && !HOST_READ_STROBE_N &&
      !HOST_SEL_B |=> HOST_MSR_DATA[4] == !$past(CTS_N_A, 2)) else $error("cts bit");
   // Own disable so the reset values themselves are seen
   a_reset_state: assert property (disable iff (1'b0) SRST |=>
      TX_A && RX_AVAIL_N_A && !TX_SPACE_N_A && !HOST_READ_ACTIVE) else $error("reset");
   a_tx_pass: assert property (1'b1 |=> TX_A == $past(TX_DATA_A)) else $error("tx");
   a_rx_ready: assert property (RX_PUSH_A && !RX_POP_A && RX_TRIG_A == 2'h0 |=>
      !RX_AVAIL_N_A) else $error("rx ready");
   a_rx_empty: assert property (RX_POP_A && !RX_PUSH_A && !FIFO_EN_A |=> RX_AVAIL_N_A)
      else $error("rx empty");
   a_tx_full: assert property (TX_PUSH_A && !TX_POP_A && !FIFO_EN_A |=> TX_SPACE_N_A)
      else $error("tx full");
endmodule // dus_properties

bind dus_top dus_properties dus_properties_i (.*);

// ==== dv/dus_modem.sv ====
// Modem model for one channel
`timescale 1ns/1ps
module dus_modem (
   input  wire logic clk, ready, carrier,
   output logic      cts_n, cd_n
);
   initial {cts_n, cd_n} = 2'h3;
   always @(posedge clk) begin
      cts_n <= #1 !ready;
      cd_n  <= #1 !carrier;
   end
endmodule // dus_modem

// ==== dv/dus_top_bench.sv ====
// Random bench for the status pins
`timescale 1ns/1ps
module dus_top_bench;
   logic       clk = 0, srst = 1, stb = 1, sel = 0, ra;
   logic [1:0] pu = 0, po = 0, qu = 0, qo = 0, fe = 3, rx = 3, td = 3, rd = 0, ca = 0;
   logic [1:0] cn, cd, tx, an, sn, rs, cr, ms = 0, tr [2] = '{2'h0, 2'h0};
   logic [7:0] modem_status_reg;
   int         err_total = 0, samples_checked = 0, rc [2], tc [2], b, lv [4] = '{1, 4, 8, 14};
   always #4 clk = ~clk;
   dus_modem dus_modem_i [1:0] (.clk(clk), .ready(rd), .carrier(ca), .cts_n(cn), .cd_n(cd));
   dus_top dus_top_i (.CLK(clk), .SRST(srst), .HOST_READ_STROBE_N(stb), .HOST_SEL_B(sel),
      .HOST_READ_ACTIVE(ra), .HOST_MSR_DATA(modem_status_reg), .RX_PUSH_A(pu[0]), .RX_POP_A(po[0]),
      .TX_PUSH_A(qu[0]), .TX_POP_A(qo[0]), .RX_PUSH_B(pu[1]), .RX_POP_B(po[1]),
      .TX_PUSH_B(qu[1]), .TX_POP_B(qo[1]), .FIFO_EN_A(fe[0]), .FIFO_EN_B(fe[1]),
      .RX_TRIG_A(tr[0]), .RX_TRIG_B(tr[1]), .RX_A(rx[0]), .RX_B(rx[1]), .TX_DATA_A(td[0]),
      .TX_DATA_B(td[1]), .TX_A(tx[0]), .TX_B(tx[1]), .RX_SEEN_A(rs[0]), .RX_SEEN_B(rs[1]),
      .CTS_N_A(cn[0]), .CTS_N_B(cn[1]), .CARRIER_DETECT_N_A(cd[0]),
      .CARRIER_DETECT_N_B(cd[1]), .CARRIER_A(cr[0]), .CARRIER_B(cr[1]), .RX_AVAIL_N_A(an[0]),
      .RX_AVAIL_N_B(an[1]), .TX_SPACE_N_A(sn[0]), .TX_SPACE_N_B(sn[1]));
   // Full push and empty pop are refused, so the count saturates
   function automatic int nxt(int n, logic i, logic o, int d);
      return n + (i && !o && n < d) - (o && !i && n > 0);
   endfunction
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      samples_checked++;
      if (s !== e) begin
         err_total++;
         $display("CHECK FAILED %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic step;
      logic [1:0] ea, es, er, ec;
      @(posedge clk);
      for (int c = 0; c < 2; c++) begin
         rc[c] = srst ? 0 : nxt(rc[c], pu[c], po[c], fe[c] ? 16 : 1);
         tc[c] = srst ? 0 : nxt(tc[c], qu[c], qo[c], fe[c] ? 16 : 1);
         ea[c] = rc[c] < (fe[c] ? lv[tr[c]] : 1);
         es[c] = tc[c] >= (fe[c] ? 16 : 1);
      end
      // Read data shows the status word registered one edge earlier
      er = {!srst && !stb && ms[sel], !srst && !stb};
      ms = srst ? 2'h0 : ~cn;
      ec = ~cd & {2{!srst}};
      #1;
      chk("rx ready", an, ea);
      chk("tx ready", sn, es);
      chk("tx pin", tx, td | {2{srst}});
      chk("rx pin", rs, rx | {2{srst}});
      chk("carrier", cr, ec);
      chk("read", ra, er[0]);
      chk("status", modem_status_reg, {3'h0, er[1], 4'h0});
      if (!srst) begin
         {stb, sel, tr[0], tr[1], rx, td, rd, ca} = 14'($urandom);
         for (int c = 0; c < 2; c++) begin
            {pu[c], po[c]} = {$urandom % 8 < b, $urandom % 8 >= b};
            {qu[c], qo[c]} = {$urandom % 8 < b, $urandom % 8 >= b};
         end
      end
   endtask
   // Bias 8 fills back to back, 0 drains; phase 4 resets mid-run
   initial begin
      void'($urandom(32'hF62D));
      repeat (12) step;
      for (int p = 0; p < 8; p++) begin
         srst = p == 4;
         fe = {2{p < 4}};
         b = p % 2 ? p / 2 : 8 - p;
         repeat (p == 4 ? 2 : 0) step;
         srst = 0;
         repeat (60) step;
      end
      finish_test;
   end
   initial begin
      #20000;
      err_total++;
      finish_test;
   end
endmodule // dus_top_bench
